/* File: common/piefu_cfg.svh */
// Purpose: constants of the interrupt and error flag command unit
// Assumes: included by its bare name wherever a constant is needed
// Notes: definitions only
`ifndef PIEFU_CFG_SVH
`define PIEFU_CFG_SVH

// ****************************************
// instruction codes
// ****************************************
`define PIEFU_OP_CLEAR_FLAGS 8'h24
`define PIEFU_OP_UNMASK 8'h19
`define PIEFU_OP_MASK 8'h1a
`define PIEFU_OP_VECTOR 8'h25
`define PIEFU_OP_RETURN 8'h26

// ****************************************
// type field values and status
// ****************************************
`define PIEFU_IRQ_GLOBAL 8'hff
`define PIEFU_FLAG_ALL 8'h00
`define PIEFU_FLAG_TIMEOUT 8'h01
`define PIEFU_FLAG_ALARM 8'h02
`define PIEFU_FLAG_DEVIATION 8'h03
`define PIEFU_FLAG_POSITION 8'h04
`define PIEFU_FLAG_SHUTDOWN 8'h05
`define PIEFU_STATUS_OK 8'h64

// ****************************************
// error flag bit positions
// ****************************************
`define PIEFU_NUM_FLAGS 5
`define PIEFU_BIT_TIMEOUT 0
`define PIEFU_BIT_ALARM 1
`define PIEFU_BIT_DEVIATION 2
`define PIEFU_BIT_POSITION 3
`define PIEFU_BIT_SHUTDOWN 4

// ****************************************
// frame byte positions, same for request and reply
// ****************************************
`define PIEFU_POS_ADDR 4'h0
`define PIEFU_POS_INSTR 4'h1
`define PIEFU_POS_TYPE 4'h2
`define PIEFU_POS_BANK 4'h3
`define PIEFU_POS_VAL3 4'h4
`define PIEFU_POS_VAL2 4'h5
`define PIEFU_POS_VAL1 4'h6
`define PIEFU_POS_VAL0 4'h7
`define PIEFU_POS_SUM 4'h8

// ****************************************
// default link addresses
// ****************************************
`define PIEFU_MODULE_ADDR_DEF 8'h01
`define PIEFU_HOST_ADDR_DEF 8'h02

`endif

/* File: common/piefu_cmd_if.sv */
// Purpose: carries a decoded link command from receiver to core
// Assumes: one clock, valid is a one-cycle pulse
// Notes: cmd is meaningful only while valid is high
`timescale 1ns/1ps
interface piefu_cmd_if;
   import piefu_pkg::*;
   logic valid;
   piefu_cmd_s cmd;
   modport rx (output valid, output cmd);
   modport core (input valid, input cmd);
endinterface

/* File: common/piefu_pkg.sv */
// Purpose: shared types of the interrupt and error flag command unit
// Assumes: nothing
// Notes: constants live in piefu_cfg.svh
package piefu_pkg;

   typedef logic [7:0] piefu_byte_t;
   typedef logic [31:0] piefu_word_t;

   // one decoded command
   typedef struct packed {
      piefu_byte_t instr;
      piefu_byte_t typ;
      piefu_byte_t bank;
      piefu_word_t value;
   } piefu_cmd_s;

   // handler state of the program
   typedef enum logic [0:0] {
      CTL_RUN = 1'b0,
      CTL_HANDLER = 1'b1
   } piefu_ctl_e;

   // reply sender state
   typedef enum logic [0:0] {
      TX_IDLE = 1'b0,
      TX_SEND = 1'b1
   } piefu_tx_e;

endpackage

/* File: core/piefu_frame_rx.sv */
// Purpose: assembles nine-byte command frames and checks them
// Assumes: bytes arrive from logic on the same clock
// Notes: a frame with bad checksum or foreign address is dropped
`timescale 1ns/1ps
`include "piefu_cfg.svh"
module piefu_frame_rx #(
   parameter logic [7:0] MODULE_ADDR = `PIEFU_MODULE_ADDR_DEF
)(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // byte stream
   input wire piefu_pkg::piefu_byte_t rx_byte_in,
   input wire logic rx_valid_in,
   // decoded command
   piefu_cmd_if.rx cmd_port
);
   import piefu_pkg::*;

   logic [3:0] cnt_q, cnt_d;
   piefu_byte_t sum_q, sum_d;
   piefu_byte_t addr_q, addr_d;
   piefu_cmd_s cmd_q, cmd_d;
   logic valid_q, valid_d;

   // ****************************************
   // frame assembly
   // ****************************************
   // byte fields fill by position; value comes most significant first
   always_comb begin
      cnt_d = cnt_q;
      sum_d = sum_q;
      addr_d = addr_q;
      cmd_d = cmd_q;
      valid_d = 1'b0;
      if (rx_valid_in) begin
         case (cnt_q)
            `PIEFU_POS_ADDR: addr_d = rx_byte_in;
            `PIEFU_POS_INSTR: cmd_d.instr = rx_byte_in;
            `PIEFU_POS_TYPE: cmd_d.typ = rx_byte_in;
            `PIEFU_POS_BANK: cmd_d.bank = rx_byte_in;
            `PIEFU_POS_VAL3: cmd_d.value[31:24] = rx_byte_in;
            `PIEFU_POS_VAL2: cmd_d.value[23:16] = rx_byte_in;
            `PIEFU_POS_VAL1: cmd_d.value[15:8] = rx_byte_in;
            `PIEFU_POS_VAL0: cmd_d.value[7:0] = rx_byte_in;
            default: ;
         endcase
         if (cnt_q == `PIEFU_POS_SUM) begin
            valid_d = (rx_byte_in == sum_q) && (addr_q == MODULE_ADDR);
            cnt_d = `PIEFU_POS_ADDR;
            sum_d = '0;
         end else begin
            cnt_d = cnt_q + 4'h1;
            sum_d = sum_q + rx_byte_in;
         end
      end
   end

   // registers of the assembler
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q <= `PIEFU_POS_ADDR;
         sum_q <= '0;
         addr_q <= '0;
         cmd_q <= '0;
         valid_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         sum_q <= sum_d;
         addr_q <= addr_d;
         cmd_q <= cmd_d;
         valid_q <= valid_d;
      end
   end

   assign cmd_port.valid = valid_q;
   assign cmd_port.cmd = cmd_q;

   chk_bad_sum_drop: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (rx_valid_in && cnt_q == `PIEFU_POS_SUM && rx_byte_in != sum_q)
      |=> !valid_q)
      else $error("frame with bad checksum was accepted");

endmodule

/* File: core/piefu_top.sv */
// Purpose: executes flag clear, irq unmask/mask, vector and return
// Assumes: all inputs come from logic on clk_in
// Notes: link frames in direct mode, program commands in standalone
`timescale 1ns/1ps
`include "piefu_cfg.svh"
module piefu_top #(
   parameter int NUM_IRQ = 8,
   parameter int FLAG_W = 8,
   parameter logic [7:0] MODULE_ADDR = `PIEFU_MODULE_ADDR_DEF,
   parameter logic [7:0] HOST_ADDR = `PIEFU_HOST_ADDR_DEF
)(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // host link bytes
   input wire piefu_pkg::piefu_byte_t rx_byte_in,
   input wire logic rx_valid_in,
   output piefu_pkg::piefu_byte_t tx_byte_out,
   output logic tx_valid_out,
   // mode select
   input wire logic standalone_in,
   // stored program command and its context
   input wire logic prog_valid_in,
   input wire piefu_pkg::piefu_byte_t prog_instr_in,
   input wire piefu_pkg::piefu_byte_t prog_type_in,
   input wire piefu_pkg::piefu_word_t prog_value_in,
   input wire piefu_pkg::piefu_word_t prog_acc_in,
   input wire piefu_pkg::piefu_word_t prog_x_in,
   input wire logic [FLAG_W-1:0] prog_flags_in,
   input wire piefu_pkg::piefu_word_t prog_pc_in,
   // event sources
   input wire logic [NUM_IRQ-1:0] irq_event_in,
   input wire logic [`PIEFU_NUM_FLAGS-1:0] err_event_in,
   // status
   output logic [`PIEFU_NUM_FLAGS-1:0] err_flags_out,
   output logic [NUM_IRQ-1:0] irq_enable_out,
   output logic [NUM_IRQ-1:0] irq_pending_out,
   output logic global_enable_out,
   output logic in_handler_out,
   // program flow control
   output logic jump_out,
   output piefu_pkg::piefu_word_t jump_addr_out,
   output logic restore_out,
   output piefu_pkg::piefu_word_t restore_acc_out,
   output piefu_pkg::piefu_word_t restore_x_out,
   output logic [FLAG_W-1:0] restore_flags_out,
   output piefu_pkg::piefu_word_t restore_pc_out
);
   import piefu_pkg::*;

   localparam int IRQ_W = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;

   // ****************************************
   // parameter checks
   // ****************************************
   if (NUM_IRQ < 1 || NUM_IRQ > 255) begin : g_bad_irq
      $error("NUM_IRQ must lie in 1..255");
   end
   if (FLAG_W < 1) begin : g_bad_flag
      $error("FLAG_W must be at least 1");
   end

   // ****************************************
   // functions
   // ****************************************
   // true when the type byte names an existing source
   function automatic logic irq_in_range(input piefu_byte_t t);
      irq_in_range = (int'(t) < NUM_IRQ);
   endfunction

   // flag bits selected by a clear type
   function automatic logic [`PIEFU_NUM_FLAGS-1:0] flag_mask(
      input piefu_byte_t t);
      flag_mask = '0;
      case (t)
         `PIEFU_FLAG_ALL: flag_mask = '1;
         `PIEFU_FLAG_TIMEOUT: flag_mask[`PIEFU_BIT_TIMEOUT] = 1'b1;
         `PIEFU_FLAG_ALARM: flag_mask[`PIEFU_BIT_ALARM] = 1'b1;
         `PIEFU_FLAG_DEVIATION: flag_mask[`PIEFU_BIT_DEVIATION] = 1'b1;
         `PIEFU_FLAG_POSITION: flag_mask[`PIEFU_BIT_POSITION] = 1'b1;
         `PIEFU_FLAG_SHUTDOWN: flag_mask[`PIEFU_BIT_SHUTDOWN] = 1'b1;
         default: flag_mask = '0;
      endcase
   endfunction

   // lowest numbered request wins
   function automatic logic [IRQ_W-1:0] first_set(
      input logic [NUM_IRQ-1:0] v);
      first_set = '0;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_set = IRQ_W'(i);
         end
      end
   endfunction

   // reply byte at a frame position
   function automatic piefu_byte_t reply_byte(input logic [3:0] pos,
      input piefu_byte_t instr);
      piefu_byte_t sum;
      sum = HOST_ADDR + MODULE_ADDR + `PIEFU_STATUS_OK + instr;
      case (pos)
         `PIEFU_POS_ADDR: reply_byte = HOST_ADDR;
         `PIEFU_POS_INSTR: reply_byte = MODULE_ADDR;
         `PIEFU_POS_TYPE: reply_byte = `PIEFU_STATUS_OK;
         `PIEFU_POS_BANK: reply_byte = instr;
         `PIEFU_POS_SUM: reply_byte = sum;
         default: reply_byte = '0;
      endcase
   endfunction

   // ****************************************
   // link receiver and command source
   // ****************************************
   piefu_cmd_if link_cmd ();

   piefu_frame_rx #(.MODULE_ADDR(MODULE_ADDR)) u_rx (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .rx_byte_in(rx_byte_in),
      .rx_valid_in(rx_valid_in),
      .cmd_port(link_cmd)
   );

   logic cmd_v;
   piefu_cmd_s cmd;
   logic is_clear, is_unmask, is_mask, is_handler_entry_define, is_ret, is_ours;
   logic type_ok, type_glob;
   logic [IRQ_W-1:0] type_idx;

   // program drives in standalone, link otherwise
   always_comb begin
      if (standalone_in) begin
         cmd_v = prog_valid_in;
         cmd = '{prog_instr_in, prog_type_in, 8'h00, prog_value_in};
      end else begin
         cmd_v = link_cmd.valid;
         cmd = link_cmd.cmd;
      end
   end

   // instruction decode
   assign is_clear = cmd_v && cmd.instr == `PIEFU_OP_CLEAR_FLAGS;
   assign is_unmask = cmd_v && cmd.instr == `PIEFU_OP_UNMASK;
   assign is_mask = cmd_v && cmd.instr == `PIEFU_OP_MASK;
   assign is_handler_entry_define = cmd_v && cmd.instr == `PIEFU_OP_VECTOR;
   assign is_ret = cmd_v && cmd.instr == `PIEFU_OP_RETURN;
   assign is_ours = is_clear | is_unmask | is_mask | is_handler_entry_define | is_ret;
   assign type_ok = irq_in_range(cmd.typ);
   assign type_glob = cmd.typ == `PIEFU_IRQ_GLOBAL;
   assign type_idx = cmd.typ[IRQ_W-1:0];

   // ****************************************
   // error flags and interrupt state
   // ****************************************
   logic [`PIEFU_NUM_FLAGS-1:0] err_q, err_d;
   logic [NUM_IRQ-1:0] en_q, en_d, pend_q, pend_d, cand;
   logic glob_q, glob_d;
   piefu_word_t vec_q [NUM_IRQ];
   piefu_word_t vec_d [NUM_IRQ];
   piefu_ctl_e ctl_q, ctl_d;
   logic take;
   logic [IRQ_W-1:0] take_idx;
   logic jump_q, jump_d, rest_q, rest_d;
   piefu_word_t jaddr_q, jaddr_d;
   piefu_word_t acc_q, acc_d, x_q, x_d, pc_q, pc_d;
   logic [FLAG_W-1:0] fl_q, fl_d;

   // a source is taken only between commands and outside a handler
   assign cand = pend_q & en_q;
   assign take = glob_q && ctl_q == CTL_RUN && !cmd_v && |cand;
   assign take_idx = first_set(cand);

   // next state of flags, masks, vectors and context
   always_comb begin
      err_d = err_q;
      en_d = en_q;
      glob_d = glob_q;
      pend_d = pend_q;
      vec_d = vec_q;
      ctl_d = ctl_q;
      jump_d = 1'b0;
      jaddr_d = jaddr_q;
      rest_d = 1'b0;
      acc_d = acc_q;
      x_d = x_q;
      fl_d = fl_q;
      pc_d = pc_q;
      // clear selected flags, new events win
      if (is_clear) begin
         err_d = err_q & ~flag_mask(cmd.typ);
      end
      err_d = err_d | err_event_in;
      // unmask one source or all processing
      if (is_unmask && type_glob) begin
         glob_d = 1'b1;
      end else if (is_unmask && type_ok) begin
         en_d[type_idx] = 1'b1;
      end
      // mask one source or all processing
      if (is_mask && type_glob) begin
         glob_d = 1'b0;
      end else if (is_mask && type_ok) begin
         en_d[type_idx] = 1'b0;
      end
      if (is_handler_entry_define && type_ok) begin
         vec_d[type_idx] = cmd.value;
      end
      if (take) begin
         pend_d[take_idx] = 1'b0;
         acc_d = prog_acc_in;
         x_d = prog_x_in;
         fl_d = prog_flags_in;
         pc_d = prog_pc_in;
         jump_d = 1'b1;
         jaddr_d = vec_q[take_idx];
         ctl_d = CTL_HANDLER;
      end
      pend_d = pend_d | irq_event_in;
      // leave handler, saved context goes back
      case (ctl_q)
         CTL_HANDLER: begin
            if (is_ret) begin
               rest_d = 1'b1;
               ctl_d = CTL_RUN;
            end
         end
         default: ;
      endcase
   end

   // registers of flags, masks, vectors and context
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         err_q <= '0;
         en_q <= '0;
         glob_q <= 1'b0;
         pend_q <= '0;
         for (int i = 0; i < NUM_IRQ; i++) begin
            vec_q[i] <= '0;
         end
         ctl_q <= CTL_RUN;
         jump_q <= 1'b0;
         jaddr_q <= '0;
         rest_q <= 1'b0;
         acc_q <= '0;
         x_q <= '0;
         fl_q <= '0;
         pc_q <= '0;
      end else begin
         err_q <= err_d;
         en_q <= en_d;
         glob_q <= glob_d;
         pend_q <= pend_d;
         vec_q <= vec_d;
         ctl_q <= ctl_d;
         jump_q <= jump_d;
         jaddr_q <= jaddr_d;
         rest_q <= rest_d;
         acc_q <= acc_d;
         x_q <= x_d;
         fl_q <= fl_d;
         pc_q <= pc_d;
      end
   end

   // ****************************************
   // reply sender
   // ****************************************
   piefu_tx_e tx_q, tx_d;
   logic [3:0] tcnt_q, tcnt_d;
   piefu_byte_t echo_q, echo_d, tbyte_q, tbyte_d;
   logic tval_q, tval_d;

   // nine-byte OK reply for link commands
   always_comb begin
      tx_d = tx_q;
      tcnt_d = tcnt_q;
      echo_d = echo_q;
      tbyte_d = tbyte_q;
      tval_d = 1'b0;
      case (tx_q)
         TX_IDLE: begin
            if (is_ours && !standalone_in) begin
               tx_d = TX_SEND;
               tcnt_d = `PIEFU_POS_ADDR;
               echo_d = cmd.instr;
            end
         end
         TX_SEND: begin
            tval_d = 1'b1;
            tbyte_d = reply_byte(tcnt_q, echo_q);
            tcnt_d = tcnt_q + 4'h1;
            if (tcnt_q == `PIEFU_POS_SUM) begin
               tx_d = TX_IDLE;
            end
         end
         default: tx_d = TX_IDLE;
      endcase
   end

   // registers of the reply sender
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_q <= TX_IDLE;
         tcnt_q <= `PIEFU_POS_ADDR;
         echo_q <= '0;
         tbyte_q <= '0;
         tval_q <= 1'b0;
      end else begin
         tx_q <= tx_d;
         tcnt_q <= tcnt_d;
         echo_q <= echo_d;
         tbyte_q <= tbyte_d;
         tval_q <= tval_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign tx_byte_out = tbyte_q;
   assign tx_valid_out = tval_q;
   assign err_flags_out = err_q;
   assign irq_enable_out = en_q;
   assign irq_pending_out = pend_q;
   assign global_enable_out = glob_q;
   assign in_handler_out = ctl_q;
   assign jump_out = jump_q;
   assign jump_addr_out = jaddr_q;
   assign restore_out = rest_q;
   assign restore_acc_out = acc_q;
   assign restore_x_out = x_q;
   assign restore_flags_out = fl_q;
   assign restore_pc_out = pc_q;

   // ****************************************
   // checks
   // ****************************************
   // clear all empties flags
   chk_clear_all_flags: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (is_clear && cmd.typ == `PIEFU_FLAG_ALL && err_event_in == '0)
      |=> err_flags_out == '0)
      else $error("clear all left a flag set");

   // single clear hits only its flag
   chk_clear_one_flag: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (is_clear && cmd.typ == `PIEFU_FLAG_TIMEOUT && err_event_in == '0)
      |=> !err_flags_out[`PIEFU_BIT_TIMEOUT] &&
          err_flags_out[`PIEFU_NUM_FLAGS-1:1] ==
          $past(err_q[`PIEFU_NUM_FLAGS-1:1]))
      else $error("timeout clear acted on the wrong flags");

   chk_unmask_source: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (is_unmask && type_ok) |=> irq_enable_out[$past(type_idx)])
      else $error("unmask did not enable the source");

   chk_global_on: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (is_unmask && type_glob) |=> global_enable_out &&
         $stable(irq_enable_out))
      else $error("global unmask misbehaved");

   chk_mask_source: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (is_mask && type_ok) |=> !irq_enable_out[$past(type_idx)])
      else $error("mask did not disable the source");

   chk_global_off: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (is_mask && type_glob) |=> !global_enable_out ##1 !jump_out)
      else $error("global mask did not stop processing");

   chk_vector_store: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (is_handler_entry_define && type_ok) |=> vec_q[$past(type_idx)] == $past(cmd.value))
      else $error("handler entry not stored");

   // jump goes to stored entry with context saved
   chk_take_jump: assert property (
      @(posedge clk_in) disable iff (rst_in)
      take |=> jump_out && in_handler_out &&
         jump_addr_out == $past(vec_q[take_idx]) &&
         restore_pc_out == $past(prog_pc_in))
      else $error("interrupt entry wrong");

   chk_return_restore: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (is_ret && ctl_q == CTL_HANDLER) |=> restore_out &&
         !in_handler_out && $stable(restore_pc_out))
      else $error("return did not restore context");

   // reply carries status OK and echo
   chk_reply_status: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (tx_q == TX_IDLE && is_ours && !standalone_in)
      |=> ##1 tx_valid_out ##2 tx_byte_out == `PIEFU_STATUS_OK
      ##1 tx_byte_out == $past(cmd.instr, 5))
      else $error("reply status or echo wrong");

endmodule

/* File: verification/piefu_host_model.sv */
// Purpose: host side of the link, sends frames and gathers replies
// Assumes: one clock, reply bytes come as tx valid pulses
// Notes: link byte idles at the inverse of the last byte sent
`timescale 1ns/1ps
module piefu_host_model (
   // clock
   input wire logic clk_in,
   // reply bytes from the unit
   input wire logic [7:0] tx_byte_in,
   input wire logic tx_valid_in,
   // command bytes to the unit
   output logic [7:0] rx_byte_out,
   output logic rx_valid_out
);
   logic [7:0] reply_q[$];
   initial begin
      rx_byte_out = 8'h00;
      rx_valid_out = 1'b0;
   end
   // gather every reply byte
   always @(posedge clk_in) begin
      if (tx_valid_in === 1'b1) begin
         reply_q.push_back(tx_byte_in);
      end
   end
   task automatic send(input logic [7:0] ins, input logic [7:0] typ,
         input logic [31:0] val, input logic bad);
      logic [7:0] fr[9];
      int i;
      fr = '{8'h01, ins, typ, 8'($urandom), val[31:24], val[23:16],
         val[15:8], val[7:0], 8'h00};
      for (i = 0; i < 8; i++) begin
         fr[8] = fr[8] + fr[i];
      end
      fr[8] = fr[8] ^ {7'h00, bad};
      for (i = 0; i < 9; i++) begin
         @(posedge clk_in);
         rx_valid_out <= 1'b1;
         rx_byte_out <= fr[i];
      end
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_byte_out <= ~fr[8];
   endtask
endmodule

/* File: verification/program_interrupt_and_error_flag_unit_tb.sv */
// Purpose: self-checking bench of the command unit
// Assumes: host model drives the link
// Notes: a plain model tracks flags, enables and the global enable
`timescale 1ns/1ps
`include "piefu_cfg.svh"
module program_interrupt_and_error_flag_unit_tb;
   import piefu_pkg::*;
   logic clk_in, rst_in, sa, pv, rxv, txv, jmp, rsto, glob, inh;
   piefu_byte_t rxb, txb, pi, pt, fl, rfl, sfl;
   piefu_word_t pval, acc, xr, pc, ja, racc, rxx, rpc, v, sacc, sx, spc;
   logic [7:0] iev, ien, ipd, m_en;
   logic [4:0] eev, efl, m_fl;
   logic m_gl;
   int err_total, samples_checked, i, t;
   // free running clock
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   piefu_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .rx_byte_in(rxb),
      .rx_valid_in(rxv), .tx_byte_out(txb), .tx_valid_out(txv),
      .standalone_in(sa), .prog_valid_in(pv), .prog_instr_in(pi),
      .prog_type_in(pt), .prog_value_in(pval), .prog_acc_in(acc),
      .prog_x_in(xr), .prog_flags_in(fl), .prog_pc_in(pc),
      .irq_event_in(iev), .err_event_in(eev), .err_flags_out(efl),
      .irq_enable_out(ien), .irq_pending_out(ipd),
      .global_enable_out(glob), .in_handler_out(inh), .jump_out(jmp),
      .jump_addr_out(ja), .restore_out(rsto), .restore_acc_out(racc),
      .restore_x_out(rxx), .restore_flags_out(rfl),
      .restore_pc_out(rpc));
   piefu_host_model u_host (.clk_in(clk_in), .tx_byte_in(txb),
      .tx_valid_in(txv), .rx_byte_out(rxb), .rx_valid_out(rxv));
   // verdict and end of run
   task automatic report_and_stop();
      if (err_total == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // one comparison
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         $display("BAD %0t got %h exp %h", $time, g, e);
         err_total++;
      end
   endtask
   // model update, then state compare
   task automatic apply(input piefu_byte_t ins, typ, input piefu_word_t val);
      case (ins)
         8'h24: begin
            if (typ == 8'h00) m_fl = 5'h00;
            else if (typ < 8'h06) m_fl[typ[2:0] - 3'h1] = 1'b0;
         end
         8'h19, 8'h1a: begin
            if (typ == 8'hff) m_gl = (ins == 8'h19);
            else if (typ < 8'h08) m_en[typ[2:0]] = (ins == 8'h19);
         end
         default: ;
      endcase
      chk(efl, m_fl);
      chk(ien, m_en);
      chk(glob, m_gl);
   endtask
   // one link frame and its reply
   task automatic link(input piefu_byte_t ins, typ, input piefu_word_t val,
         input logic bad);
      piefu_byte_t e[9];
      int k;
      e = '{8'h02, 8'h01, `PIEFU_STATUS_OK, ins, 8'h00, 8'h00, 8'h00, 8'h00,
         8'h00};
      for (k = 0; k < 8; k++) begin
         e[8] = e[8] + e[k];
      end
      u_host.reply_q.delete();
      u_host.send(ins, typ, val, bad);
      for (k = 0; k < 30 && u_host.reply_q.size() < 9; k++) begin
         @(negedge clk_in);
      end
      if (!bad && k == 30) begin
         err_total++;
         report_and_stop();
      end
      chk(u_host.reply_q.size(), bad ? 0 : 9);
      for (k = 0; k < u_host.reply_q.size(); k++) begin
         chk(u_host.reply_q[k], e[k]);
      end
      apply(bad ? 8'h00 : ins, typ, val);
   endtask
   // one stored program command
   task automatic prog(input piefu_byte_t ins, typ, input piefu_word_t val);
      @(posedge clk_in);
      pv <= 1'b1;
      pi <= ins;
      pt <= typ;
      pval <= val;
      @(posedge clk_in);
      pv <= 1'b0;
      @(negedge clk_in);
      apply(ins, typ, val);
   endtask
   // main sequence
   initial begin
      void'($urandom(32'hdb5b587d));
      {rst_in, sa, pv, pi, pt, pval, acc, xr, fl, pc} = {1'b1, 154'h0};
      {iev, eev, m_fl, m_en, m_gl, err_total, samples_checked} = 0;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      @(negedge clk_in);
      chk({txv, jmp, rsto, inh, ipd}, 12'h000);
      apply(8'h00, 8'h00, 0);
      // raise all flags, clear by type 1..5 and 0, then a bad sum
      for (t = 0; t < 7; t++) begin
         @(posedge clk_in);
         eev <= 5'h1f;
         @(posedge clk_in);
         eev <= 5'h00;
         m_fl = 5'h1f;
         link(8'h24, 8'((t + 1) % 6), $urandom, t == 6);
      end
      for (t = 0; t < 8; t++) begin
         link(8'h19, t[7:0], $urandom, 1'b0);
      end
      link(8'h1a, 8'($urandom % 8), 0, 1'b0);
      link(8'h19, 8'hff, 0, 1'b0);
      link(8'h1a, 8'hff, 0, 1'b0);
      link(8'h19, 8'hff, 0, 1'b0);
      link(8'h26, 8'hff, 0, 1'b0);
      link(8'h25, 8'h03, $urandom, 1'b0);
      // standalone: redefine vector, take source 3, return
      @(posedge clk_in);
      sa <= 1'b1;
      v = $urandom;
      prog(8'h25, 8'h03, v);
      prog(8'h19, 8'h03, 0);
      @(posedge clk_in);
      {acc, xr, pc} <= {$urandom, $urandom, $urandom};
      fl <= 8'($urandom);
      iev <= 8'h08;
      @(posedge clk_in);
      iev <= 8'h00;
      {sacc, sx, spc, sfl} = {acc, xr, pc, fl};
      for (i = 0; i < 10 && jmp !== 1'b1; i++) begin
         @(negedge clk_in);
      end
      chk(i < 10, 1);
      if (i == 10) begin
         report_and_stop();
      end
      chk(ja, v);
      chk({inh, rfl}, {1'b1, sfl});
      chk(racc, sacc);
      chk(ipd, 8'h00);
      @(posedge clk_in);
      {acc, xr, pc} <= ~{sacc, sx, spc};
      prog(8'h26, 8'h00, 0);
      chk({rsto, inh, rfl}, {2'b10, sfl});
      chk(racc, sacc);
      chk(rxx, sx);
      chk(rpc, spc);
      report_and_stop();
   end
endmodule
